// File: shared/obt_params.svh
// Purpose : constants for the registered bus transceiver
// Assumes : one 50 MHz reference clock
// Notes   : widths, reset values, buffer depth and idle control levels only
`ifndef OBT_PARAMS_SVH
`define OBT_PARAMS_SVH
`define OBT_WIDTH      8
`define OBT_REG_RESET  8'h00
`define OBT_BUF_DEPTH  2
// idle levels of the six synchronised controls: only the b-to-a enable is high
`define OBT_CTL_IDLE   6'h10
`endif

// File: shared/obt_pkg.sv
// Purpose : shared types of the registered bus transceiver
// Assumes : obt_params.svh supplies the width
// Notes   : drive modes of one direction
`include "obt_params.svh"
package obt_pkg;
   typedef logic [`OBT_WIDTH-1:0] obt_word_t;
   // one-hot drive mode of one direction
   typedef enum logic [2:0] {
      OBT_OFF    = 3'h1,
      OBT_LIVE   = 3'h2,
      OBT_STORED = 3'h4
   } obt_mode_t;
endpackage : obt_pkg

// File: shared/obt_stream_if.sv
// Purpose : valid/ready word carrier between transceiver modules
// Assumes : single clock domain
// Notes   : source drives valid and data, sink drives ready
interface obt_stream_if;
   logic              valid;
   logic              ready;
   obt_pkg::obt_word_t data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : obt_stream_if

// File: hw/obt_skid_buf.sv
// Purpose : two-entry buffer in the captured-data path
// Assumes : one clock, asynchronous active-low reset
// Notes   : full and empty are exact; ready drops when both slots hold data
`include "obt_params.svh"
module obt_skid_buf (
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   obt_stream_if.snk in_s,
   obt_stream_if.src out_s
);
   obt_pkg::obt_word_t mem [2];
   logic [1:0]         count;
   logic               rd_ptr;
   logic               wr_ptr;
   logic [1:0]         next_count;
   logic               next_rd_ptr;
   logic               next_wr_ptr;
   logic               push;
   logic               pop;

   // handshakes on both sides
   always_comb begin
      push        = in_s.valid && (count != 2'h2);
      pop         = out_s.ready && (count != 2'h0);
      next_count  = count + {1'b0, push} - {1'b0, pop};
      next_wr_ptr = wr_ptr ^ push;
      next_rd_ptr = rd_ptr ^ pop;
   end

   // register pointers and storage
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count  <= 2'h0;
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         mem[0] <= `OBT_REG_RESET;
         mem[1] <= `OBT_REG_RESET;
      end else begin
         count  <= next_count;
         rd_ptr <= next_rd_ptr;
         wr_ptr <= next_wr_ptr;
         if (push) begin
            mem[wr_ptr] <= in_s.data;
         end
      end
   end

   assign in_s.ready  = (count != 2'h2);
   assign out_s.valid = (count != 2'h0);
   assign out_s.data  = mem[rd_ptr];

   cnt_bound_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
      count <= 2'h2) else $error("buffer count above two");
endmodule : obt_skid_buf

// File: hw/obt_transceiver.sv
// Notes on behaviour
// RQ1: select low live, high stored data
// RQ2: capture clock edges always load registers
// RQ3: enables alone decide which port drives
// RQ4: B driven from live A
// RQ5: B driven from A register
// RQ6: A driven from live B
// RQ7: A driven from B register
// RQ8: both ports driven from opposite registers
// RQ9: A-to-B only: both registers load
// RQ10: B-to-A only: both registers load
// RQ11: controller staggers clocks in stored mode
// RQ12: both live enables form hold loop
// RQ13: eight identical bit channels
// RQ14: every path inverts its source
//
// Purpose : octal registered bus transceiver with inverting paths
// Assumes : pins and capture clocks are asynchronous, sampled by 50 MHz i_ref_clk
// Notes   : oe outputs are low while driving; pad resolves wire level
`include "obt_params.svh"
module obt_transceiver #(
   parameter int WIDTH = `OBT_WIDTH
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_a_to_b_drive_enable,
   input  wire logic             i_b_to_a_drive_enable_n,
   input  wire logic             i_a_side_capture_clock,
   input  wire logic             i_b_side_capture_clock,
   input  wire logic             i_b_side_source_select,
   input  wire logic             i_a_side_source_select,
   input  wire logic [WIDTH-1:0] i_port_a_lines,
   input  wire logic [WIDTH-1:0] i_port_b_lines,
   output logic      [WIDTH-1:0] o_port_a_lines,
   output logic                  o_port_a_lines_oe_n,
   output logic      [WIDTH-1:0] o_port_b_lines,
   output logic                  o_port_b_lines_oe_n,
   output logic      [WIDTH-1:0] o_a_capture_reg,
   output logic      [WIDTH-1:0] o_b_capture_reg,
   input  wire logic             i_cap_ready,
   output logic                  o_cap_valid,
   output logic      [WIDTH-1:0] o_cap_data,
   output logic                  o_cap_overrun
);
   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   localparam int NC = WIDTH * 2 + 6;
   // chains reset to idle pin levels so no port drives just after reset
   localparam logic [NC-1:0] SYNC_IDLE = {{(NC-6){1'b0}}, `OBT_CTL_IDLE};
   logic [NC-1:0] sync1;
   logic [NC-1:0] sync2;
   logic [NC-1:0] next_sync1;
   logic [NC-1:0] next_sync2;

   // two flops per asynchronous pin
   always_comb begin
      next_sync1 = {i_port_a_lines, i_port_b_lines, i_a_to_b_drive_enable,
                    i_b_to_a_drive_enable_n, i_a_side_capture_clock,
                    i_b_side_capture_clock, i_b_side_source_select,
                    i_a_side_source_select};
      next_sync2 = sync1;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1 <= SYNC_IDLE;
         sync2 <= SYNC_IDLE;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
      end
   end

   logic [WIDTH-1:0] a_in;
   logic [WIDTH-1:0] b_in;
   logic             ab_en;
   logic             ba_en_n;
   logic             clk_a;
   logic             clk_b;
   logic             sel_b;
   logic             sel_a;
   assign {a_in, b_in, ab_en, ba_en_n, clk_a, clk_b, sel_b, sel_a} = sync2;

   // ****************************************************************
   // capture registers
   // ****************************************************************
   logic                clk_a_d;
   logic                clk_b_d;
   logic                rise_a;
   logic                rise_b;
   obt_pkg::obt_word_t  a_reg;
   obt_pkg::obt_word_t  b_reg;
   obt_pkg::obt_word_t  next_a_reg;
   obt_pkg::obt_word_t  next_b_reg;
   logic [WIDTH-1:0]    a_seen;
   logic [WIDTH-1:0]    b_seen;

   // the value seen on a pin is our own drive when that port is driven
   always_comb begin
      a_seen     = o_port_a_lines_oe_n ? a_in : o_port_a_lines;
      b_seen     = o_port_b_lines_oe_n ? b_in : o_port_b_lines;
      rise_a     = clk_a && !clk_a_d;
      rise_b     = clk_b && !clk_b_d;
      next_a_reg = rise_a ? a_seen : a_reg; // see RQ2 see RQ10
      next_b_reg = rise_b ? b_seen : b_reg; // see RQ2 see RQ9
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         clk_a_d <= 1'b0;
         clk_b_d <= 1'b0;
         a_reg   <= `OBT_REG_RESET;
         b_reg   <= `OBT_REG_RESET;
      end else begin
         clk_a_d <= clk_a;
         clk_b_d <= clk_b;
         a_reg   <= next_a_reg;
         b_reg   <= next_b_reg;
      end
   end

   // ****************************************************************
   // drive modes and port outputs
   // ****************************************************************
   obt_pkg::obt_mode_t next_mode_b;
   obt_pkg::obt_mode_t next_mode_a;
   logic [WIDTH-1:0]   next_out_a;
   logic [WIDTH-1:0]   next_out_b;
   logic               loop_hold;

   // enable picks drive, select picks live or stored source
   always_comb begin
      next_mode_b = !ab_en ? obt_pkg::OBT_OFF :                       // see RQ3
                    (sel_b ? obt_pkg::OBT_STORED : obt_pkg::OBT_LIVE); // see RQ1
      next_mode_a = ba_en_n ? obt_pkg::OBT_OFF :                      // see RQ3
                    (sel_a ? obt_pkg::OBT_STORED : obt_pkg::OBT_LIVE); // see RQ1
      // inverting paths; live paths read the pin as last seen, so
      // both live drivers together latch bus A at its driven level and bus B at its inverse
      unique case (next_mode_b)
         obt_pkg::OBT_OFF:    next_out_b = o_port_b_lines;
         obt_pkg::OBT_LIVE:   next_out_b = ~a_seen;  // see RQ4 see RQ12 see RQ14
         obt_pkg::OBT_STORED: next_out_b = ~a_reg;   // see RQ5 see RQ8 see RQ14
      endcase
      // once both ports drive live, A keeps its level and B follows it;
      // a loop entered from both sides at once would otherwise swap levels
      loop_hold = !o_port_a_lines_oe_n && !o_port_b_lines_oe_n &&
                  (next_mode_b == obt_pkg::OBT_LIVE);
      unique case (next_mode_a)
         obt_pkg::OBT_OFF:    next_out_a = o_port_a_lines;
         obt_pkg::OBT_LIVE:   begin // see RQ6 see RQ12 see RQ14
            next_out_a = loop_hold ? o_port_a_lines : ~b_seen;
         end
         obt_pkg::OBT_STORED: next_out_a = ~b_reg;   // see RQ7 see RQ8 see RQ14
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_port_a_lines      <= '0;
         o_port_b_lines      <= '0;
         o_port_a_lines_oe_n <= 1'b1;
         o_port_b_lines_oe_n <= 1'b1;
      end else begin
         o_port_a_lines      <= next_out_a;
         o_port_b_lines      <= next_out_b;
         o_port_a_lines_oe_n <= (next_mode_a == obt_pkg::OBT_OFF); // see RQ3
         o_port_b_lines_oe_n <= (next_mode_b == obt_pkg::OBT_OFF); // see RQ3
      end
   end

   // ****************************************************************
   // capture stream through the two-entry buffer
   // ****************************************************************
   obt_stream_if cap_in ();
   obt_stream_if cap_out ();
   logic next_overrun;

   // each A-side capture is offered downstream; a refused word is flagged
   assign cap_in.valid  = rise_a;
   assign cap_in.data   = a_seen;
   assign cap_out.ready = i_cap_ready || !o_cap_valid;
   assign next_overrun  = o_cap_overrun || (rise_a && !cap_in.ready);

   obt_skid_buf u_buf (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .in_s      (cap_in),
      .out_s     (cap_out)
   );

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cap_valid     <= 1'b0;
         o_cap_data      <= '0;
         o_cap_overrun   <= 1'b0;
         o_a_capture_reg <= `OBT_REG_RESET;
         o_b_capture_reg <= `OBT_REG_RESET;
      end else begin
         if (cap_out.ready) begin
            o_cap_valid <= cap_out.valid;
            o_cap_data  <= cap_out.data;
         end
         o_cap_overrun   <= next_overrun;
         o_a_capture_reg <= next_a_reg; // see RQ13
         o_b_capture_reg <= next_b_reg;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence s_a_edge;
      !clk_a ##1 clk_a;
   endsequence

   cap_a_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ2
      s_a_edge |-> ##1 (a_reg == $past(a_seen)))
      else $error("a register missed capture");
   cap_b_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ2
      (!clk_b ##1 clk_b) |-> ##1 (b_reg == $past(b_seen)))
      else $error("b register missed capture");
   b_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ3
      !ab_en |=> o_port_b_lines_oe_n)
      else $error("port b driven while disabled");
   a_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ3
      ba_en_n |=> o_port_a_lines_oe_n)
      else $error("port a driven while disabled");
   b_live_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ4
      (ab_en && !sel_b && o_port_a_lines_oe_n) |=> (o_port_b_lines == ~$past(a_in)))
      else $error("port b not inverse of live a");
   b_stored_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ5
      (ab_en && sel_b) |=> (o_port_b_lines == ~$past(a_reg)))
      else $error("port b not inverse of a register");
   a_live_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ6
      (!ba_en_n && !sel_a && o_port_b_lines_oe_n) |=> (o_port_a_lines == ~$past(b_in)))
      else $error("port a not inverse of live b");
   a_stored_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ7
      (!ba_en_n && sel_a) |=> (o_port_a_lines == ~$past(b_reg)))
      else $error("port a not inverse of b register");
   both_stored_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ8
      (ab_en && !ba_en_n && sel_a && sel_b)[*2] |->
      (!o_port_a_lines_oe_n && !o_port_b_lines_oe_n))
      else $error("both ports not driven");
   hold_loop_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see RQ12
      (ab_en && !ba_en_n && !sel_a && !sel_b)[*3] |=> $stable(o_port_b_lines))
      else $error("hold loop drifted");
endmodule : obt_transceiver

// File: dv/obt_bus_model.sv
// Purpose : model of one external parallel bus
// Assumes : design output enable is low while it drives
// Notes   : no keeper; an undriven line shows a level flipping each cycle
module obt_bus_model (
   input  wire logic               i_ref_clk,
   input  wire logic               i_ext_en,
   input  wire obt_pkg::obt_word_t i_ext_val,
   input  wire obt_pkg::obt_word_t i_drv,
   input  wire logic               i_drv_oe_n,
   output obt_pkg::obt_word_t      o_lines
);
   timeunit 1ns;
   timeprecision 1ps;
   obt_pkg::obt_word_t last = 8'h00;
   // wire level: device first, then the outside source, else floating
   always_comb begin
      if (!i_drv_oe_n) o_lines = i_drv;
      else if (i_ext_en) o_lines = i_ext_val;
      else o_lines = ~last;
   end
   // remember the level so a floating line keeps changing
   always @(posedge i_ref_clk) last <= o_lines;
endmodule : obt_bus_model

// File: dv/obt_transceiver_tb_top.sv
// Purpose : self-checking bench of the registered bus transceiver
// Assumes : 50 MHz clock, inputs driven on the falling edge
// Notes   : pin effects land three clock edges after a change
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module obt_transceiver_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ********************************
   // stimulus and observed signals
   // ********************************
   logic i_ref_clk = 1'b0, i_rst_n = 1'b0, ab = 1'b0, ba_n = 1'b1, ca = 1'b0, cb = 1'b0;
   logic sb = 1'b0, sa = 1'b0, ea = 1'b1, eb = 1'b1, rdy = 1'b1;
   obt_pkg::obt_word_t va = 8'h00, vb = 8'h00, bus_a, bus_b, a_o, b_o, areg, breg, cdat;
   logic oe_a_n, oe_b_n, cval, ovr;
   int checks = 0, bad_count = 0;
   always #10 i_ref_clk = ~i_ref_clk;
   obt_transceiver u_obt_transceiver (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
      .i_a_to_b_drive_enable(ab), .i_b_to_a_drive_enable_n(ba_n),
      .i_a_side_capture_clock(ca), .i_b_side_capture_clock(cb),
      .i_b_side_source_select(sb), .i_a_side_source_select(sa),
      .i_port_a_lines(bus_a), .i_port_b_lines(bus_b), .o_port_a_lines(a_o),
      .o_port_a_lines_oe_n(oe_a_n), .o_port_b_lines(b_o), .o_port_b_lines_oe_n(oe_b_n),
      .o_a_capture_reg(areg), .o_b_capture_reg(breg), .i_cap_ready(rdy),
      .o_cap_valid(cval), .o_cap_data(cdat), .o_cap_overrun(ovr));
   obt_bus_model u_obt_bus_model_a (.i_ref_clk(i_ref_clk), .i_ext_en(ea), .i_ext_val(va),
      .i_drv(a_o), .i_drv_oe_n(oe_a_n), .o_lines(bus_a));
   obt_bus_model u_obt_bus_model_b (.i_ref_clk(i_ref_clk), .i_ext_en(eb), .i_ext_val(vb),
      .i_drv(b_o), .i_drv_oe_n(oe_b_n), .o_lines(bus_b));
   // ********************************
   // shared steps
   // ********************************
   task automatic settle; repeat (3) @(negedge i_ref_clk); endtask : settle
   task automatic ctl(input logic e1, input logic e2_n, input logic s1, input logic s2);
      ab = e1; ba_n = e2_n; sb = s1; sa = s2; settle();
   endtask : ctl
   // capture clocks held high and low long enough to be seen
   task automatic pulse(input logic a, input logic b);
      ca = a; cb = b; settle(); ca = 1'b0; cb = 1'b0; settle();
   endtask : pulse
   task automatic take(input obt_pkg::obt_word_t e);
      for (int i = 0; i < 10 && cval !== 1'b1; i++) @(negedge i_ref_clk);
      `CHK(cdat, e)
      rdy = 1'b1; @(negedge i_ref_clk); rdy = 1'b0;
   endtask : take
   // ********************************
   // scenarios
   // ********************************
   task automatic t_reset;
      `CHK({oe_a_n, oe_b_n, cval, ovr}, 4'hc)
      `CHK({areg, breg}, 16'h0000)
      $display("test reset done");
   endtask : t_reset
   task automatic t_live_ab;
      ctl(1'b1, 1'b1, 1'b0, 1'b0);
      for (int i = 0; i < 2; i++) begin
         va = i ? 8'ha5 : 8'h5a; settle();
         `CHK(b_o, ~va)
         `CHK({oe_a_n, oe_b_n}, 2'h2)
      end
      $display("test live a to b done");
   endtask : t_live_ab
   task automatic t_store;
      ctl(1'b0, 1'b1, 1'b1, 1'b1); va = 8'h3c; vb = 8'hc3; settle();
      pulse(1'b1, 1'b1);
      `CHK({areg, breg}, 16'h3cc3)
      ctl(1'b1, 1'b1, 1'b1, 1'b0); va = 8'hff; settle();
      `CHK(b_o, 8'hc3)
      ctl(1'b0, 1'b0, 1'b0, 1'b1); ea = 1'b0;
      `CHK(a_o, 8'h3c)
      vb = 8'h96; ctl(1'b0, 1'b0, 1'b0, 1'b0);
      `CHK(a_o, 8'h69)
      eb = 1'b0; ctl(1'b1, 1'b0, 1'b1, 1'b1);
      `CHK({a_o, b_o, oe_a_n, oe_b_n}, 18'h0f30c)
      $display("test stored paths done");
   endtask : t_store
   task automatic t_both_regs;
      ctl(1'b0, 1'b1, 1'b0, 1'b0); ea = 1'b1; va = 8'h12; ctl(1'b1, 1'b1, 1'b0, 1'b0);
      pulse(1'b1, 1'b1);
      `CHK({areg, breg}, 16'h12ed)
      ctl(1'b0, 1'b1, 1'b0, 1'b0); ea = 1'b0; eb = 1'b1; vb = 8'h34;
      ctl(1'b0, 1'b0, 1'b0, 1'b0);
      pulse(1'b1, 1'b1);
      `CHK({areg, breg}, 16'hcb34)
      $display("test both registers done");
   endtask : t_both_regs
   task automatic t_hold;
      ctl(1'b0, 1'b1, 1'b0, 1'b0); ea = 1'b1; eb = 1'b0; va = 8'h77;
      ctl(1'b1, 1'b1, 1'b0, 1'b0);
      ctl(1'b1, 1'b0, 1'b0, 1'b0); ea = 1'b0; settle(); settle();
      `CHK({bus_a, bus_b, oe_a_n, oe_b_n}, 18'h1de20)
      $display("test hold loop done");
   endtask : t_hold
   task automatic t_stream;
      ctl(1'b0, 1'b1, 1'b0, 1'b0); ea = 1'b1; eb = 1'b1; rdy = 1'b0;
      // four captures: one in the output stage, two buffered, the last refused
      for (int i = 1; i < 5; i++) begin
         va = 8'(i * 17); settle(); pulse(1'b1, 1'b0);
      end
      `CHK({cval, cdat, ovr}, 10'h223)
      take(8'h11);
      take(8'h22);
      take(8'h33);
      settle();
      `CHK({cval, ovr}, 2'h1)
      rdy = 1'b1;
      $display("test capture stream done");
   endtask : t_stream
   // ********************************
   // run control
   // ********************************
   task automatic final_report;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   initial begin
      #50000;
      bad_count++;
      final_report();
   end
   initial begin
      repeat (12) @(negedge i_ref_clk);
      i_rst_n = 1'b1;
      @(negedge i_ref_clk);
      t_reset();
      t_live_ab();
      t_store();
      t_both_regs();
      t_hold();
      t_stream();
      final_report();
   end
endmodule : obt_transceiver_tb_top
